/* src/ipc_core.sv */
// Purpose: Interrupt priority controller with AXI4-Lite register access
// Assumes: Sequencer strobes sample_strobe once per machine cycle
// Notes: Pins arrive active low and pass two flip-flops
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ipc_core
	import ipc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read channels
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Sequencer and peripherals
	input wire ipc_seq_type seq_in,
	input wire ipc_evt_type evt_in,
	input wire logic [1:0] ext_pin_n,
	input wire logic watchdog_status_bit,
	// Call, watchdog and timer2 reload
	output ipc_call_type call_out,
	output logic watchdog_refresh_pulse,
	output logic watchdog_start_pulse,
	output logic timer2_reload_action
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [SEL_N-1:0] ipc_decode(input logic [ADDR_W-1:0] a);
		logic [SEL_N-1:0] s;
		s = '0;
		case (a[ADDR_W-1:2])
			IDX_EN_PRI: s[SEL_EN_PRI] = 1'b1;
			IDX_PRIO_LO: s[SEL_PRIO_LO] = 1'b1;
			IDX_EN_SEC: s[SEL_EN_SEC] = 1'b1;
			IDX_PRIO_HI: s[SEL_PRIO_HI] = 1'b1;
			IDX_AUX: s[SEL_AUX] = 1'b1;
			IDX_STATUS: s[SEL_STATUS] = 1'b1;
			IDX_FLAGS: s[SEL_FLAGS] = 1'b1;
			default: s = '0;
		endcase
		return s;
	endfunction : ipc_decode

	// Result is {found, source, level}
	function automatic logic [6:0] ipc_pick(input logic [11:0] c, input logic [5:0] lo,
		input logic [5:0] hi);
		logic [6:0] r;
		r = '0;
		for (int l = 3; l >= 0; l--) begin
			for (int p = 0; p < NUM_PAIRS; p++) begin
				if (!r[6] && {hi[p], lo[p]} == 2'(l)) begin // RULE7 RULE9 RULE10
					if (c[p]) begin // RULE11
						r = {1'b1, 4'(p), 2'(l)};
					end else if (c[p + NUM_PAIRS]) begin
						r = {1'b1, 4'(p + NUM_PAIRS), 2'(l)};
					end
				end
			end
		end
		return r;
	endfunction : ipc_pick

	function automatic logic [15:0] ipc_vector(input logic [3:0] s);
		if (s < 4'(NUM_PAIRS)) begin
			return VEC_LEFT_BASE + VEC_STEP * 16'(s); // RULE19
		end
		return VEC_RIGHT_BASE + VEC_STEP * 16'(s - 4'(NUM_PAIRS));
	endfunction : ipc_vector

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [ADDR_W-1:0] aw_addr_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] w_data_reg;
	logic w_lane0_reg;
	logic [7:0] en_pri_reg;
	logic [7:0] en_sec_reg;
	logic [5:0] prio_lo_reg;
	logic [5:0] prio_hi_reg;
	logic [7:0] aux_reg;
	logic [7:0] aux_next;
	logic [7:0] flag_reg;
	logic [7:0] flag_next;
	logic [3:0] prog_reg;
	logic hold_reg;
	logic [11:0] sample_reg;
	logic [1:0] pin_s1_reg;
	logic [1:0] pin_s2_reg;
	logic [1:0] pin_prev_reg;
	logic wr_go;
	logic wr_en;
	logic [SEL_N-1:0] wr_sel;
	logic [SEL_N-1:0] rd_sel;
	logic [7:0] rd_byte;
	logic acc_now;
	logic [1:0] edge_n;
	logic [11:0] req;
	logic [11:0] cand;
	logic [6:0] pick;
	logic [3:0] win_src;
	logic [1:0] win_lvl;
	logic blocked;
	logic fire;
	logic [11:0] vec_clr;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	assign wr_go = aw_held_reg && w_held_reg && !bvalid;
	assign wr_sel = ipc_decode(aw_addr_reg);
	assign wr_en = wr_go && w_lane0_reg;
	assign rd_sel = ipc_decode(araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			awready <= 1'b1;
			aw_addr_reg <= '0;
		end else if (awvalid && awready) begin
			aw_held_reg <= 1'b1;
			awready <= 1'b0;
			aw_addr_reg <= awaddr;
		end else if (wr_go) begin
			aw_held_reg <= 1'b0;
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			wready <= 1'b1;
			w_data_reg <= RST_BYTE;
			w_lane0_reg <= 1'b0;
		end else if (wvalid && wready) begin
			w_held_reg <= 1'b1;
			wready <= 1'b0;
			w_data_reg <= wdata[7:0];
			w_lane0_reg <= wstrb[0];
		end else if (wr_go) begin
			w_held_reg <= 1'b0;
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp <= (wr_sel != '0) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_comb begin
		rd_byte = RST_BYTE;
		if (rd_sel[SEL_EN_PRI]) rd_byte = en_pri_reg;
		if (rd_sel[SEL_EN_SEC]) rd_byte = en_sec_reg;
		if (rd_sel[SEL_PRIO_LO]) rd_byte = {1'b0, watchdog_status_bit, prio_lo_reg}; // RULE6
		if (rd_sel[SEL_PRIO_HI]) rd_byte = {2'b00, prio_hi_reg};
		if (rd_sel[SEL_AUX]) rd_byte = aux_reg;
		if (rd_sel[SEL_STATUS]) rd_byte = {3'b000, hold_reg, prog_reg};
		if (rd_sel[SEL_FLAGS]) rd_byte = flag_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h000000, rd_byte};
			rresp <= (rd_sel != '0) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Enable and priority registers
	// ----------------------------------------
	// Watchdog bits are strobes and never stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_pri_reg <= RST_BYTE;
			en_sec_reg <= RST_BYTE;
			prio_lo_reg <= RST_BYTE[5:0];
			prio_hi_reg <= RST_BYTE[5:0];
		end else if (wr_en) begin
			if (wr_sel[SEL_EN_PRI]) en_pri_reg <= w_data_reg & EN_WR_MASK; // RULE2
			if (wr_sel[SEL_EN_SEC]) en_sec_reg <= w_data_reg & EN_WR_MASK; // RULE3
			if (wr_sel[SEL_PRIO_LO]) prio_lo_reg <= w_data_reg[5:0]; // RULE7
			if (wr_sel[SEL_PRIO_HI]) prio_hi_reg <= w_data_reg[5:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_refresh_pulse <= 1'b0;
			watchdog_start_pulse <= 1'b0;
			timer2_reload_action <= 1'b0;
		end else begin
			watchdog_refresh_pulse <= wr_en && wr_sel[SEL_EN_PRI] && w_data_reg[WD_REFRESH_BIT]; // RULE5
			watchdog_start_pulse <= wr_en && wr_sel[SEL_EN_SEC] && w_data_reg[WD_START_BIT];
			timer2_reload_action <= evt_in.t2_reload; // RULE4
		end
	end

	// ----------------------------------------
	// External pins 0 and 1
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_reg <= 2'b11;
			pin_s2_reg <= 2'b11;
			pin_prev_reg <= 2'b11;
		end else begin
			pin_s1_reg <= ext_pin_n;
			pin_s2_reg <= pin_s1_reg;
			if (seq_in.sample_strobe) pin_prev_reg <= pin_s2_reg;
		end
	end

	// High sample then low sample, one per machine cycle
	assign edge_n = {2{seq_in.sample_strobe}} & pin_prev_reg & ~pin_s2_reg; // RULE22

	// ----------------------------------------
	// Request flags
	// ----------------------------------------
	// Hardware sets are applied last so they beat any clear
	always_comb begin
		aux_next = aux_reg;
		if (wr_en && wr_sel[SEL_AUX]) aux_next = w_data_reg; // RULE25
		aux_next[AUX_REQ0] = (aux_next[AUX_REQ0] && !vec_clr[0]) || edge_n[0];
		aux_next[AUX_T0OVF] = (aux_next[AUX_T0OVF] && !vec_clr[1]) || evt_in.t0_ovf;
		aux_next[AUX_REQ1] = (aux_next[AUX_REQ1] && !vec_clr[2]) || edge_n[1];
		aux_next[AUX_T1OVF] = (aux_next[AUX_T1OVF] && !vec_clr[3]) || evt_in.t1_ovf;
		aux_next[AUX_URX] = aux_next[AUX_URX] || evt_in.uart_rx;
		aux_next[AUX_UTX] = aux_next[AUX_UTX] || evt_in.uart_tx;
		// Level mode: pin owns the flag, writes have no effect
		if (!aux_reg[AUX_EDGE0]) aux_next[AUX_REQ0] = !pin_s2_reg[0]; // RULE22 RULE25
		if (!aux_reg[AUX_EDGE1]) aux_next[AUX_REQ1] = !pin_s2_reg[1];
	end

	always_comb begin
		flag_next = flag_reg;
		if (wr_en && wr_sel[SEL_FLAGS]) flag_next = w_data_reg; // RULE25
		flag_next[FLG_EXT_LO +: 5] = (flag_next[FLG_EXT_LO +: 5] & ~vec_clr[11:7])
			| evt_in.ext_hi; // RULE17
		flag_next[FLG_CONV] = flag_next[FLG_CONV] || evt_in.conv_done;
		flag_next[FLG_T2OVF] = flag_next[FLG_T2OVF] || evt_in.t2_ovf;
		flag_next[FLG_T2RLD] = flag_next[FLG_T2RLD]
			|| (evt_in.t2_reload && en_sec_reg[T2_RELOAD_EN_BIT]); // RULE4
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_reg <= RST_BYTE;
			flag_reg <= RST_BYTE;
		end else begin
			aux_reg <= aux_next;
			flag_reg <= flag_next;
		end
	end

	// ----------------------------------------
	// Sampling and polling
	// ----------------------------------------
	assign req = {flag_reg[FLG_EXT_LO +: 5], flag_reg[FLG_CONV],
		flag_reg[FLG_T2OVF] | flag_reg[FLG_T2RLD], aux_reg[AUX_URX] | aux_reg[AUX_UTX],
		aux_reg[AUX_T1OVF], aux_reg[AUX_REQ1], aux_reg[AUX_T0OVF], aux_reg[AUX_REQ0]}; // RULE24

	// Overwritten every machine cycle, so a refused request is forgotten
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sample_reg <= '0;
		end else if (seq_in.sample_strobe) begin
			sample_reg <= req; // RULE12 RULE15
		end
	end

	assign cand = sample_reg & {en_sec_reg[5:0], en_pri_reg[5:0]}
		& {12{en_pri_reg[GLOBAL_EN_BIT]}}; // RULE1 RULE2 RULE3
	assign pick = ipc_pick(cand, prio_lo_reg, prio_hi_reg);
	assign win_src = pick[5:2];
	assign win_lvl = pick[1:0];
	assign acc_now = (wr_go && ((wr_sel & SEL_IRQ_REGS) != '0))
		|| (arvalid && arready && ((rd_sel & SEL_IRQ_REGS) != '0));
	assign blocked = ((prog_reg >> win_lvl) != 4'h0) || !seq_in.last_cycle // RULE8 RULE13
		|| hold_reg || acc_now || seq_in.irq_exit_exec; // RULE14
	assign fire = seq_in.sample_strobe && pick[6] && !blocked;
	assign vec_clr = fire ? ((12'h001 << win_src) & CLR_ON_CALL
		& ~{9'h000, !aux_reg[AUX_EDGE1], 1'b0, !aux_reg[AUX_EDGE0]}) : 12'h000; // RULE16

	// One further instruction must finish before the next call
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_reg <= 1'b0;
		end else if (seq_in.irq_exit_exec || acc_now) begin
			hold_reg <= 1'b1; // RULE14
		end else if (seq_in.sample_strobe && seq_in.last_cycle) begin
			hold_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Level markers and call
	// ----------------------------------------
	// Plain returns are invisible here, so their level stays marked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_reg <= 4'h0;
		end else if (seq_in.irq_exit_exec) begin
			for (int l = 3; l >= 0; l--) begin
				if (prog_reg[l] && (prog_reg >> l) == 4'h1) prog_reg[l] <= 1'b0; // RULE20 RULE21
			end
		end else if (fire) begin
			prog_reg[win_lvl] <= 1'b1; // RULE26
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			call_out <= CALL_IDLE; // RULE18
		end else begin
			call_out.valid <= fire;
			if (fire) call_out.vector <= ipc_vector(win_src); // RULE19
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_GLOBAL_GATE: assert property ( // RULE1
		call_out.valid |-> $past(en_pri_reg[GLOBAL_EN_BIT]))
		else $error("call with global enable off");
	AST_SRC_GATE: assert property ( // RULE2
		fire |-> (({en_sec_reg[5:0], en_pri_reg[5:0]} >> win_src) & 12'h001) != 12'h000)
		else $error("call for a disabled source");
	AST_TOP_LEVEL: assert property ( // RULE8
		prog_reg[3] |=> !call_out.valid)
		else $error("level 3 routine pre-empted");
	AST_HIGHER_FIRST: assert property ( // RULE9
		fire && cand[6] |-> win_lvl >= {prio_hi_reg[0], prio_lo_reg[0]})
		else $error("lower level chosen first");
	AST_EQUAL_ORDER: assert property ( // RULE10
		fire && cand[6] && cand[4] && !cand[0] && win_lvl == {prio_hi_reg[0], prio_lo_reg[0]}
		&& win_lvl == {prio_hi_reg[4], prio_lo_reg[4]} |-> win_src == 4'h6)
		else $error("pair order not kept");
	AST_PAIR_LEFT: assert property ( // RULE11
		fire && cand[0] && cand[6] |-> win_src != 4'h6)
		else $error("right source before left");
	AST_FINAL_CYCLE: assert property ( // RULE13
		call_out.valid |-> $past(seq_in.last_cycle && seq_in.sample_strobe))
		else $error("call outside final poll");
	AST_EXIT_HOLD: assert property ( // RULE14
		seq_in.irq_exit_exec |=> hold_reg && !call_out.valid)
		else $error("call right after exit");
	AST_EDGE_CLEAR: assert property ( // RULE16
		fire && win_src == 4'h0 && aux_reg[AUX_EDGE0] && !edge_n[0] && !wr_en
		|=> !aux_reg[AUX_REQ0])
		else $error("edge flag kept after call");
	AST_UART_KEEP: assert property ( // RULE16
		fire && win_src == 4'h4 && !wr_en |=> (aux_reg[AUX_URX] || !$past(aux_reg[AUX_URX]))
		&& (aux_reg[AUX_UTX] || !$past(aux_reg[AUX_UTX])))
		else $error("serial flag cleared by call");
	AST_EXT_CLEAR: assert property ( // RULE17
		fire && win_src == 4'h7 && !wr_en && !evt_in.ext_hi[0] |=> !flag_reg[FLG_EXT_LO])
		else $error("ext2 flag kept after call");
	AST_VEC_FORM: assert property ( // RULE19
		fire && win_src == 4'h7 |=> call_out.valid && call_out.vector == 16'h004b
		&& !call_out.save_status)
		else $error("wrong vector or status saved");
	AST_EXIT_LEVEL: assert property ( // RULE20
		seq_in.irq_exit_exec && prog_reg == 4'h6 |=> prog_reg == 4'h2)
		else $error("exit did not end top level");
	AST_LEVEL_MODE: assert property ( // RULE22
		!aux_reg[AUX_EDGE0] && !(wr_en && wr_sel[SEL_AUX])
		|=> aux_reg[AUX_REQ0] == !$past(pin_s2_reg[0]))
		else $error("level flag not following pin");

	COV_CALL: cover property (call_out.valid);
	COV_PREEMPT: cover property (fire && prog_reg != 4'h0);
	COV_EXIT: cover property (seq_in.irq_exit_exec ##1 hold_reg);
endmodule : ipc_core
`default_nettype wire

/* src/ipc_pkg.sv */
// Purpose: Constants and carriers for the interrupt priority controller
// Assumes: 8-bit registers, one per aligned word of a 32-bit AXI4-Lite bus
// Notes: Byte address of a register is four times its index
// Notes on behaviour
// [RULE1] Global enable low acknowledges nothing; high lets per-source enables gate.
// [RULE2] Primary enable bits 0-5 gate ext0, timer0, ext1, timer1, serial, timer2.
// [RULE3] Secondary enable bits 0-5 gate converter and external interrupts 2 to 6.
// [RULE4] Reload enable gates only the reload request; the reload itself always happens.
// [RULE5] Writing one to either watchdog bit restarts or starts the watchdog.
// [RULE6] Low priority bit 6 shows watchdog status; other top bits are reserved.
// [RULE7] Pair level is {high bit, low bit}; 3 is highest, 0 lowest.
// [RULE8] Only a strictly higher level pre-empts; level 3 is never pre-empted.
// [RULE9] Among pending levels the highest level is vectored first.
// [RULE10] Equal levels resolve by fixed pair order, first pair highest.
// [RULE11] Both sources of a pair pending: the left source wins.
// [RULE12] Flags captured each machine cycle, evaluated in the next one.
// [RULE13] No call while equal or higher level runs or instruction not final.
// [RULE14] After exit or access to enable/priority registers, one more instruction runs.
// [RULE15] A blocked request is not remembered.
// [RULE16] Ext0/1 flags cleared on call only in edge mode; serial, timer2, converter never.
// [RULE17] External interrupt 2-6 flags always cleared on call.
// [RULE18] Call pushes only the program counter, never the status word.
// [RULE19] Fixed vectors: left sources 0003h step 8, right sources 0043h step 8.
// [RULE20] Interrupt exit ends the current level; two bytes are popped.
// [RULE21] A plain subroutine return leaves the level marked in progress.
// [RULE22] Ext0/1 request while pin low, or on high-then-low samples in edge mode.
// [RULE23] Level-mode requester holds pin until called and releases before routine ends.
// [RULE24] Serial request is receive OR transmit; timer2 is overflow OR reload.
// [RULE25] Software sets and clears flags; writing ext0/1 flags in level mode does nothing.
// [RULE26] One in-progress marker per level sets the pre-emption threshold.
package ipc_pkg;
	// ----------------------------------------
	// Sizes and register map
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int NUM_PAIRS = 6;
	localparam int SEL_N = 7;
	localparam logic [9:0] IDX_EN_PRI = 10'h0a8;
	localparam logic [9:0] IDX_PRIO_LO = 10'h0a9;
	localparam logic [9:0] IDX_EN_SEC = 10'h0b8;
	localparam logic [9:0] IDX_PRIO_HI = 10'h0b9;
	localparam logic [9:0] IDX_AUX = 10'h090;
	localparam logic [9:0] IDX_STATUS = 10'h091;
	localparam logic [9:0] IDX_FLAGS = 10'h0c0;
	localparam int SEL_EN_PRI = 0;
	localparam int SEL_PRIO_LO = 1;
	localparam int SEL_EN_SEC = 2;
	localparam int SEL_PRIO_HI = 3;
	localparam int SEL_AUX = 4;
	localparam int SEL_STATUS = 5;
	localparam int SEL_FLAGS = 6;
	localparam logic [SEL_N-1:0] SEL_IRQ_REGS = 7'h0f;
	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int GLOBAL_EN_BIT = 7;
	localparam int WD_REFRESH_BIT = 6;
	localparam int WD_START_BIT = 6;
	localparam int T2_RELOAD_EN_BIT = 7;
	localparam logic [7:0] EN_WR_MASK = 8'hbf;
	localparam int AUX_EDGE0 = 0;
	localparam int AUX_REQ0 = 1;
	localparam int AUX_EDGE1 = 2;
	localparam int AUX_REQ1 = 3;
	localparam int AUX_T0OVF = 4;
	localparam int AUX_T1OVF = 5;
	localparam int AUX_URX = 6;
	localparam int AUX_UTX = 7;
	localparam int FLG_CONV = 0;
	localparam int FLG_EXT_LO = 1;
	localparam int FLG_T2OVF = 6;
	localparam int FLG_T2RLD = 7;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [11:0] CLR_ON_CALL = 12'hf8f;
	localparam logic [15:0] VEC_LEFT_BASE = 16'h0003;
	localparam logic [15:0] VEC_RIGHT_BASE = 16'h0043;
	localparam logic [15:0] VEC_STEP = 16'h0008;
	localparam logic [1:0] PC_BYTES = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic sample_strobe;
		logic last_cycle;
		logic irq_exit_exec;
	} ipc_seq_type;
	typedef struct packed {
		logic t0_ovf;
		logic t1_ovf;
		logic uart_rx;
		logic uart_tx;
		logic t2_ovf;
		logic t2_reload;
		logic conv_done;
		logic [4:0] ext_hi;
	} ipc_evt_type;
	typedef struct packed {
		logic valid;
		logic [15:0] vector;
		logic save_status;
		logic [1:0] stack_bytes;
	} ipc_call_type;
	localparam ipc_call_type CALL_IDLE = '{1'b0, 16'h0000, 1'b0, PC_BYTES};
endpackage : ipc_pkg

/* test/ipc_seq_model.sv */
// Purpose: Sequencer and pin requester model facing the interrupt controller
// Assumes: One machine cycle lasts four clocks
// Notes: The pin 0 requester holds its pin low until the call to its vector
`timescale 1ns/100ps
`default_nettype none
module ipc_seq_model
	import ipc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench commands
	input wire logic slow,
	input wire logic exit_req,
	input wire logic pin_req,
	// Controller side
	input wire ipc_call_type call_out,
	output ipc_seq_type seq_in,
	output logic [1:0] ext_pin_n
);
	logic [1:0] phase_reg;
	logic odd_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= 2'h0;
			odd_reg <= 1'b0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			if (phase_reg == 2'h3) begin
				odd_reg <= !odd_reg;
			end
		end
	end
	// Slow mode: only every other machine cycle ends an instruction
	always_ff @(posedge aclk) begin
		seq_in.sample_strobe <= aresetn && (phase_reg == 2'h3);
		seq_in.last_cycle <= !slow || odd_reg;
		seq_in.irq_exit_exec <= aresetn && exit_req;
	end
	// Released on the call, so no second request follows
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_pin_n <= 2'h3;
		end else if (call_out.valid && call_out.vector == 16'h0003) begin
			ext_pin_n[0] <= 1'b1;
		end else if (pin_req) begin
			ext_pin_n[0] <= 1'b0;
		end
	end
endmodule : ipc_seq_model
`default_nettype wire

/* test/tb_interrupt_priority_controller.sv */
// Purpose: Self-checking bench for the interrupt priority controller
// Assumes: Sequencer model beside the core, AXI4-Lite master tasks
// Notes: Drivers queue expected results; a monitor pops and compares them
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_priority_controller import ipc_pkg::*; ;
	localparam logic [11:0] A_EN0 = {IDX_EN_PRI, 2'b00};
	localparam logic [11:0] A_LO = {IDX_PRIO_LO, 2'b00};
	localparam logic [11:0] A_EN1 = {IDX_EN_SEC, 2'b00};
	localparam logic [11:0] A_HI = {IDX_PRIO_HI, 2'b00};
	localparam logic [11:0] A_AUX = {IDX_AUX, 2'b00};
	localparam logic [11:0] A_FLG = {IDX_FLAGS, 2'b00};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = '0;
	logic [11:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic wds = 1'b0, slow = 1'b0, exit_req = 1'b0, pin_req = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, wd_ref, wd_st, t2_act;
	logic [1:0] bresp, rresp, ext_pin_n;
	logic [31:0] rdata, r;
	ipc_seq_type seq_in;
	ipc_evt_type evt_in = '0;
	ipc_evt_type e;
	ipc_call_type call_out;
	logic [33:0] exp_r[$];
	logic [1:0] exp_b[$];
	logic [15:0] exp_v[$];
	logic [15:0] v;
	int bad_count = 0, check_count = 0, seed = 78, n_wd = 0, n_t2 = 0, i;

	ipc_core dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .seq_in(seq_in),
		.evt_in(evt_in), .ext_pin_n(ext_pin_n), .watchdog_status_bit(wds), .call_out(call_out),
		.watchdog_refresh_pulse(wd_ref), .watchdog_start_pulse(wd_st), .timer2_reload_action(t2_act)
	);
	ipc_seq_model partner (
		.aclk(aclk), .aresetn(aresetn), .slow(slow), .exit_req(exit_req), .pin_req(pin_req),
		.call_out(call_out), .seq_in(seq_in), .ext_pin_n(ext_pin_n)
	);

	initial begin
		forever #20 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [33:0] ex, input logic [33:0] s);
		check_count++;
		if (s !== ex) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, ex, s);
		end
	endtask : chk

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize

	task automatic guard(input int n);
		if (n >= 400) begin
			bad_count++;
			summarize();
		end
	endtask : guard

	// ----------------------------------------
	// Bus and sequencer drivers
	// ----------------------------------------
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rs = RESP_OKAY,
		input logic [3:0] st = 4'hf);
		int n = 0;
		exp_b.push_back(rs);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			awvalid <= awvalid && !awready;
			wvalid <= wvalid && !wready;
			bready <= bready && !bvalid;
		end while ((awvalid || wvalid || bready) && n < 400);
		guard(n);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rs = RESP_OKAY);
		int n = 0;
		exp_r.push_back({rs, 24'h0, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			arvalid <= arvalid && !arready;
			rready <= rready && !rvalid;
		end while ((arvalid || rready) && n < 400);
		guard(n);
	endtask : rd

	// Waits out queued calls, then watches for strays
	task automatic settle;
		int n = 0;
		while (exp_v.size() > 0 && n < 400) begin
			@(posedge aclk);
			n++;
		end
		guard(n);
		repeat (32) @(posedge aclk);
	endtask : settle

	task automatic fire(input ipc_evt_type ev);
		evt_in <= ev;
		@(posedge aclk);
		evt_in <= '0;
		settle();
	endtask : fire

	task automatic ex;
		exit_req <= 1'b1;
		@(posedge aclk);
		exit_req <= 1'b0;
		settle();
	endtask : ex

	task automatic pin;
		pin_req <= 1'b1;
		@(posedge aclk);
		pin_req <= 1'b0;
		settle();
	endtask : pin

	always @(posedge aclk) begin
		n_wd += wd_ref + wd_st;
		n_t2 += t2_act;
		if (bvalid && bready) chk("bresp", exp_b.pop_front(), bresp);
		if (rvalid && rready) chk("read", exp_r.pop_front(), {rresp, rdata});
		if (call_out.valid) begin
			v = exp_v.size() > 0 ? exp_v.pop_front() : 16'hffff;
			chk("call", {v, 1'b0, 2'h2}, {call_out.vector, call_out.save_status, call_out.stack_bytes});
		end
	end

	initial begin
		r = $random(seed);
		wds <= r[0];
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(A_EN0, 8'h00);
		rd(A_EN1, 8'h00);
		rd(A_LO, {1'b0, wds, 6'h00});
		rd(12'h004, 8'h00, RESP_SLVERR);
		wr(12'h004, 8'hff, RESP_SLVERR);
		for (i = 0; i < 3; i++) begin
			r = $random(seed);
			wr(A_HI, r[7:0], RESP_OKAY, {r[10:8], 1'b1});
			rd(A_HI, r[7:0] & 8'h3f);
		end
		// Lane 0 off: answered, but nothing stored
		wr(A_HI, 8'h15, RESP_OKAY, {r[11:9], 1'b0});
		rd(A_HI, r[7:0] & 8'h3f);
		wr(A_LO, 8'hff);
		rd(A_LO, {1'b0, wds, 6'h3f});
		wr(A_EN0, 8'h40);
		wr(A_EN1, 8'h40);
		rd(A_EN0, 8'h00);
		chk("watchdog pulses", 34'h2, n_wd);
		$display("test registers done");
		wr(A_HI, 8'h00);
		wr(A_LO, 8'h00);
		wr(A_EN1, 8'h3f);
		wr(A_EN0, 8'h3f);
		e = '0;
		e.ext_hi[1] = 1'b1;
		fire(e);
		rd(A_FLG, 8'h04);
		wr(A_FLG, 8'h00);
		e = '0;
		e.t2_reload = 1'b1;
		fire(e);
		rd(A_FLG, 8'h00);
		wr(A_EN1, 8'hbf);
		fire(e);
		rd(A_FLG, 8'h80);
		chk("reload actions", 34'h2, n_t2);
		wr(A_FLG, 8'h00);
		$display("test enables done");
		slow <= 1'b1;
		wr(A_EN1, 8'h3f);
		wr(A_HI, 8'h20);
		wr(A_LO, 8'h22);
		wr(A_EN0, 8'hbf);
		e = '0;
		e.conv_done = 1'b1;
		e.t0_ovf = 1'b1;
		e.ext_hi[0] = 1'b1;
		e.ext_hi[4] = 1'b1;
		exp_v.push_back(16'h006b);
		fire(e);
		exp_v.push_back(16'h000b);
		ex();
		exp_v.push_back(16'h004b);
		ex();
		rd(A_FLG, 8'h01);
		rd(A_AUX, 8'h00);
		exp_v.push_back(16'h0043);
		ex();
		e = '0;
		e.uart_tx = 1'b1;
		fire(e);
		exp_v.push_back(16'h0043);
		ex();
		wr(A_FLG, 8'h00);
		exp_v.push_back(16'h0023);
		ex();
		rd(A_AUX, 8'h80);
		wr(A_AUX, 8'h00);
		ex();
		slow <= 1'b0;
		$display("test priorities done");
		wr(A_EN0, 8'h81);
		exp_v.push_back(16'h0003);
		pin();
		rd(A_AUX, 8'h00);
		ex();
		wr(A_AUX, 8'h01);
		exp_v.push_back(16'h0003);
		pin();
		rd(A_AUX, 8'h01);
		ex();
		$display("test external pins done");
		summarize();
	end
endmodule : tb_interrupt_priority_controller
`default_nettype wire
